//--- hdl/spu_uart.sv
// Operation
// - Baud divisor register covers bit rates from 50 to 921600 bps.
// - Parity is none, odd, even, forced one or forced zero.
// - Toggle mode keeps request-to-send inactive while nothing waits to send.
// - Toggle mode raises request-to-send before data, drops it after completion.
// - Toggle mode applies programmable 0-100 ms on and off delays.
// - Line interface selects single-ended, 2-wire, 4-wire or point-to-point differential.
module spu_uart
  import spu_pkg::*;
#(
  parameter int unsigned MS_CYC = spu_pkg::MS_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire spu_pkg::spu_axi_req_t axi_req,
  output spu_pkg::spu_axi_rsp_t      axi_rsp,
  input  wire spu_pkg::spu_ser_in_t  ser_in,
  output spu_pkg::spu_ser_out_t      ser_out
);
  import spu_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_LEAD  = 3'b001,
    T_START = 3'b010,
    T_DATA  = 3'b011,
    T_PAR   = 3'b100,
    T_STOP  = 3'b101,
    T_TAIL  = 3'b110
  } spu_tx_st_t;

  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_PAR   = 3'b011,
    R_STOP  = 3'b100
  } spu_rx_st_t;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    spu_axi_rsp_t rsp;
    logic [19:0] baud;
    logic [8:0]  cfg;
    logic [6:0]  on_ms;
    logic [6:0]  off_ms;
    logic        perr;
    logic        ferr;
    logic        ovr;
    logic [2:0]  rx_s;
    logic [2:0]  cts_s;
    logic        rxd_f;
    logic        cts_f;
    spu_tx_st_t  tx_st;
    logic [19:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic [19:0] ms_div;
    logic [6:0]  ms_num;
    spu_ser_out_t ser;
    spu_rx_st_t  rx_st;
    logic [19:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_pe;
  } spu_st_t;

  localparam spu_st_t ST_RST = '{
    baud:   BAUD_RST,
    cfg:    CFG_RST,
    on_ms:  DLY_RST,
    off_ms: DLY_RST,
    rx_s:   3'h7,
    cts_s:  3'h7,
    rxd_f:  1'b1,
    cts_f:  1'b0,
    ser:    '{txd: 1'b1, rts_n: 1'b0, de: 1'b0, re_n: 1'b0},
    tx_st:  T_IDLE,
    rx_st:  R_IDLE,
    default: '0
  };

  spu_st_t    s_r;
  spu_st_t    s_nxt;
  logic       txb_rdy;
  logic       txb_v;
  logic [7:0] txb_d;
  logic       rxb_rdy;
  logic       rxb_v;
  logic [7:0] rxb_d;
  logic       tx_push;
  logic       tx_take;
  logic       rx_push;
  logic       rx_pop;

  spu_par_t   par;
  spu_flow_t  flow;
  spu_if_t    ifc;
  logic       rx_room;
  logic       tx_go;
  logic       tx_end;
  logic       rx_end;
  logic       ms_tick;
  logic [31:0] mrg;
  logic [31:0] rd;
  logic [1:0] rr;

  assign axi_rsp = s_r.rsp;
  assign ser_out = s_r.ser;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive holding buffers
  spu_buf #(.W(8), .DEPTH(2)) u_txb (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (tx_push),
    .in_data   (s_r.w_data[7:0]),
    .in_ready  (txb_rdy),
    .out_valid (txb_v),
    .out_data  (txb_d),
    .out_ready (tx_take)
  );

  spu_buf #(.W(8), .DEPTH(2)) u_rxb (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_push),
    .in_data   (s_r.rx_sh),
    .in_ready  (rxb_rdy),
    .out_valid (rxb_v),
    .out_data  (rxb_d),
    .out_ready (rx_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt   = s_r;
    tx_push = 1'b0;
    tx_take = 1'b0;
    rx_push = 1'b0;
    rx_pop  = 1'b0;
    rd      = '0;
    rr      = RESP_OKAY;
    par     = spu_par_t'(s_r.cfg[CFG_PAR_LSB +: 3]);
    flow    = spu_flow_t'(s_r.cfg[CFG_FLOW_LSB +: 2]);
    ifc     = spu_if_t'(s_r.cfg[CFG_IF_LSB +: 2]);
    rx_room = s_r.cfg[CFG_FIFO] ? rxb_rdy : !rxb_v;
    tx_go   = txb_v && (flow != FLOW_HW || s_r.cts_f);
    tx_end  = (s_r.tx_cnt >= s_r.baud - 20'h00001);
    rx_end  = (s_r.rx_cnt >= s_r.baud - 20'h00001);
    ms_tick = (s_r.ms_div == 20'(MS_CYC - 1));
    mrg     = spu_merge('0, s_r.w_data, s_r.w_strb);

    // Bus write: address and data held separately, then applied together
    if (axi_req.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_r.rsp.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid &&
        (s_r.aw_addr != ADDR_TXDATA || !s_r.w_strb[0] || txb_rdy)) begin
      s_nxt.aw_have    = 1'b0;
      s_nxt.w_have     = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp  = RESP_OKAY;
      case (s_r.aw_addr)
        ADDR_BAUD: begin
          s_nxt.baud = 20'(spu_merge({12'h000, s_r.baud}, s_r.w_data, s_r.w_strb));
        end
        ADDR_CFG: begin
          s_nxt.cfg = 9'(spu_merge({23'h000000, s_r.cfg}, s_r.w_data, s_r.w_strb));
        end
        ADDR_RTSDLY: begin
          if (s_r.w_strb[0]) begin
            s_nxt.on_ms = (mrg[6:0] > DLY_MAX) ? DLY_MAX : mrg[6:0];
          end
          if (s_r.w_strb[2]) begin
            s_nxt.off_ms = (mrg[22:16] > DLY_MAX) ? DLY_MAX : mrg[22:16];
          end
        end
        ADDR_TXDATA: begin
          tx_push = s_r.w_strb[0];
        end
        ADDR_STATUS: begin
          if (s_r.w_strb[0]) begin
            s_nxt.perr = s_r.perr && !s_r.w_data[ST_PERR];
            s_nxt.ferr = s_r.ferr && !s_r.w_data[ST_FERR];
            s_nxt.ovr  = s_r.ovr && !s_r.w_data[ST_OVR];
          end
        end
        default: begin
          s_nxt.rsp.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.rsp.awready = !s_nxt.aw_have && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready  = !s_nxt.w_have && !s_nxt.rsp.bvalid;

    // Bus read
    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_r.rsp.arready) begin
      case (axi_req.araddr)
        ADDR_BAUD:   rd = {12'h000, s_r.baud};
        ADDR_CFG:    rd = {23'h000000, s_r.cfg};
        ADDR_RTSDLY: rd = {9'h000, s_r.off_ms, 9'h000, s_r.on_ms};
        ADDR_TXDATA: rd = '0;
        ADDR_RXDATA: begin
          rd     = {23'h000000, rxb_v, rxb_d};
          rx_pop = rxb_v;
        end
        ADDR_STATUS: rd = {24'h000000, s_r.cts_f, !s_r.ser.rts_n, s_r.ovr, s_r.ferr,
                           s_r.perr, (s_r.tx_st != T_IDLE), !txb_rdy, rxb_v};
        default:     rr = RESP_SLVERR;
      endcase
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata  = rd;
      s_nxt.rsp.rresp  = rr;
    end
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once the second and third stage agree
    s_nxt.rx_s  = {s_r.rx_s[1:0], ser_in.rxd};
    s_nxt.cts_s = {s_r.cts_s[1:0], ser_in.cts_n};
    if (s_r.rx_s[1] == s_r.rx_s[2]) begin
      s_nxt.rxd_f = s_r.rx_s[2];
    end
    if (s_r.cts_s[1] == s_r.cts_s[2]) begin
      s_nxt.cts_f = !s_r.cts_s[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    s_nxt.tx_cnt = tx_end ? '0 : s_r.tx_cnt + 20'h00001;
    s_nxt.ms_div = ms_tick ? '0 : s_r.ms_div + 20'h00001;
    if (ms_tick) begin
      s_nxt.ms_num = s_r.ms_num + 7'h01;
    end
    case (s_r.tx_st)
      T_IDLE: begin
        s_nxt.ser.txd = 1'b1;
        if (flow == FLOW_TOGGLE) begin
          s_nxt.ser.rts_n = 1'b1;
        end
        if (tx_go) begin
          s_nxt.ms_div = '0;
          s_nxt.ms_num = '0;
          s_nxt.tx_st  = (flow == FLOW_TOGGLE) ? T_LEAD : T_START;
          if (flow == FLOW_TOGGLE) begin
            s_nxt.ser.rts_n = 1'b0;
          end else begin
            tx_take       = 1'b1;
            s_nxt.tx_sh   = txb_d;
            s_nxt.tx_cnt  = '0;
            s_nxt.ser.txd = 1'b0;
          end
        end
      end
      T_LEAD: begin
        if (s_r.ms_num >= s_r.on_ms) begin
          tx_take       = 1'b1;
          s_nxt.tx_sh   = txb_d;
          s_nxt.tx_cnt  = '0;
          s_nxt.ser.txd = 1'b0;
          s_nxt.tx_st   = T_START;
        end
      end
      T_START: begin
        if (tx_end) begin
          s_nxt.tx_st   = T_DATA;
          s_nxt.tx_bit  = '0;
          s_nxt.ser.txd = s_r.tx_sh[0];
        end
      end
      T_DATA: begin
        if (tx_end) begin
          s_nxt.tx_bit  = s_r.tx_bit + 3'h1;
          s_nxt.ser.txd = s_r.tx_sh[s_r.tx_bit + 3'h1];
          if (s_r.tx_bit == 3'h7) begin
            s_nxt.tx_bit = '0;
            if (par != PAR_NONE) begin
              s_nxt.tx_st   = T_PAR;
              s_nxt.ser.txd = spu_par_bit(par, s_r.tx_sh);
            end else begin
              s_nxt.tx_st   = T_STOP;
              s_nxt.ser.txd = 1'b1;
            end
          end
        end
      end
      T_PAR: begin
        if (tx_end) begin
          s_nxt.tx_st   = T_STOP;
          s_nxt.ser.txd = 1'b1;
        end
      end
      T_STOP: begin
        if (tx_end) begin
          if (s_r.tx_bit == 3'h0 && s_r.cfg[CFG_STOP2]) begin
            s_nxt.tx_bit = 3'h1;
          end else if (tx_go) begin
            tx_take       = 1'b1;
            s_nxt.tx_sh   = txb_d;
            s_nxt.ser.txd = 1'b0;
            s_nxt.tx_st   = T_START;
          end else begin
            s_nxt.ms_div = '0;
            s_nxt.ms_num = '0;
            s_nxt.tx_st  = (flow == FLOW_TOGGLE) ? T_TAIL : T_IDLE;
          end
        end
      end
      T_TAIL: begin
        if (s_r.ms_num >= s_r.off_ms) begin
          s_nxt.ser.rts_n = 1'b1;
          s_nxt.tx_st     = T_IDLE;
        end
      end
      default: s_nxt.tx_st = T_IDLE;
    endcase
    if (flow == FLOW_NONE) begin
      s_nxt.ser.rts_n = 1'b0;
    end else if (flow == FLOW_HW) begin
      s_nxt.ser.rts_n = !rx_room;
    end

    // Line driver enables per interface mode
    case (ifc)
      IF_SINGLE: begin
        s_nxt.ser.de   = 1'b0;
        s_nxt.ser.re_n = 1'b0;
      end
      IF_2WIRE: begin
        s_nxt.ser.de   = (s_nxt.tx_st >= T_START) && (s_nxt.tx_st <= T_STOP);
        s_nxt.ser.re_n = s_nxt.ser.de;
      end
      default: begin
        s_nxt.ser.de   = 1'b1;
        s_nxt.ser.re_n = 1'b0;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Receiver; in 2-wire mode our own echo is ignored
    s_nxt.rx_cnt = rx_end ? '0 : s_r.rx_cnt + 20'h00001;
    case (s_r.rx_st)
      R_IDLE: begin
        s_nxt.rx_cnt = '0;
        if (!s_r.rxd_f && !s_r.ser.re_n) begin
          s_nxt.rx_st = R_START;
        end
      end
      R_START: begin
        if (s_r.rx_cnt >= {1'b0, s_r.baud[19:1]}) begin
          s_nxt.rx_cnt = '0;
          s_nxt.rx_bit = '0;
          s_nxt.rx_pe  = 1'b0;
          s_nxt.rx_st  = s_r.rxd_f ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (rx_end) begin
          s_nxt.rx_sh[s_r.rx_bit] = s_r.rxd_f;
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == 3'h7) begin
            s_nxt.rx_st = (par != PAR_NONE) ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (rx_end) begin
          s_nxt.rx_pe = (s_r.rxd_f != spu_par_bit(par, s_r.rx_sh));
          s_nxt.rx_st = R_STOP;
        end
      end
      R_STOP: begin
        if (rx_end) begin
          s_nxt.rx_st = R_IDLE;
          rx_push     = rx_room;
          if (!rx_room) begin
            s_nxt.ovr = 1'b1;
          end
          if (!s_r.rxd_f) begin
            s_nxt.ferr = 1'b1;
          end
          if (s_r.rx_pe) begin
            s_nxt.perr = 1'b1;
          end
        end
      end
      default: s_nxt.rx_st = R_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

//--- hdl/spu_pkg.sv
package spu_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int unsigned BAUD_RST_BPS  = 115200;
  localparam int unsigned BAUD_MIN_BPS  = 50;
  localparam int unsigned BAUD_MAX_BPS  = 921600;
  localparam int unsigned RTS_DLY_MAX_MS = 100;

  localparam logic [7:0]  ADDR_BAUD   = 8'h00;
  localparam logic [7:0]  ADDR_CFG    = 8'h04;
  localparam logic [7:0]  ADDR_RTSDLY = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA = 8'h0C;
  localparam logic [7:0]  ADDR_RXDATA = 8'h10;
  localparam logic [7:0]  ADDR_STATUS = 8'h14;

  localparam int unsigned CFG_PAR_LSB  = 0;
  localparam int unsigned CFG_STOP2    = 3;
  localparam int unsigned CFG_FLOW_LSB = 4;
  localparam int unsigned CFG_FIFO     = 6;
  localparam int unsigned CFG_IF_LSB   = 7;
  localparam int unsigned DLY_OFF_LSB  = 16;
  localparam int unsigned ST_PERR      = 3;
  localparam int unsigned ST_FERR      = 4;
  localparam int unsigned ST_OVR       = 5;

  localparam logic [19:0] BAUD_RST   = 20'(CLK_HZ / BAUD_RST_BPS);
  localparam logic [8:0]  CFG_RST    = 9'h040;
  localparam logic [6:0]  DLY_RST    = 7'h00;
  localparam logic [6:0]  DLY_MAX    = 7'(RTS_DLY_MAX_MS);
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PAR_NONE  = 3'b000,
    PAR_ODD   = 3'b001,
    PAR_EVEN  = 3'b010,
    PAR_MARK  = 3'b011,
    PAR_SPACE = 3'b100
  } spu_par_t;

  typedef enum logic [1:0] {
    FLOW_NONE   = 2'b00,
    FLOW_HW     = 2'b01,
    FLOW_TOGGLE = 2'b10
  } spu_flow_t;

  typedef enum logic [1:0] {
    IF_SINGLE = 2'b00,
    IF_2WIRE  = 2'b01,
    IF_4WIRE  = 2'b10,
    IF_P2P    = 2'b11
  } spu_if_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } spu_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spu_axi_rsp_t;

  typedef struct packed {
    logic rxd;
    logic cts_n;
  } spu_ser_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic de;
    logic re_n;
  } spu_ser_out_t;

  function automatic logic spu_par_bit(input logic [2:0] mode, input logic [7:0] d);
    case (mode)
      PAR_ODD:  spu_par_bit = ~(^d);
      PAR_EVEN: spu_par_bit = ^d;
      PAR_MARK: spu_par_bit = 1'b1;
      default:  spu_par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] spu_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      spu_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

endpackage

//--- hdl/spu_buf.sv
module spu_buf #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } spu_buf_st_t;

  spu_buf_st_t s_r;
  spu_buf_st_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

//--- sim/spu_uart_props.sv
module spu_uart_props
  import spu_pkg::*;
#(
  parameter int unsigned MS_CYC = 10000
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire spu_pkg::spu_axi_req_t axi_req,
  input wire spu_pkg::spu_axi_rsp_t axi_rsp,
  input wire spu_pkg::spu_ser_in_t  ser_in,
  input wire spu_pkg::spu_ser_out_t ser_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0]  cfg_r;
  logic [6:0]  on_r;
  logic [6:0]  off_r;
  logic [31:0] lo_r;
  logic [31:0] hi_r;
  logic        wr;
  logic        tog;
  logic        map;
  assign wr  = axi_req.awvalid & axi_rsp.awready & axi_req.wvalid & axi_rsp.wready;
  assign tog = cfg_r[5:4] == FLOW_TOGGLE;
  assign map = axi_req.awaddr[1:0] == 2'h0 && axi_req.awaddr <= ADDR_STATUS;
  //////////
  // Shadow of the settings, taken at the write handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RST;
      on_r  <= DLY_RST;
      off_r <= DLY_RST;
    end else if (wr && axi_req.awaddr == ADDR_CFG) begin
      cfg_r <= axi_req.wdata[8:0];
    end else if (wr && axi_req.awaddr == ADDR_RTSDLY) begin
      on_r  <= (axi_req.wdata[6:0] > DLY_MAX) ? DLY_MAX : axi_req.wdata[6:0];
      off_r <= (axi_req.wdata[22:16] > DLY_MAX) ? DLY_MAX : axi_req.wdata[22:16];
    end
  end
  // Cycles with request-to-send active, and with the line idle
  always_ff @(posedge aclk) begin
    lo_r <= (!aresetn || ser_out.rts_n) ? 32'h0 : lo_r + 32'h1;
    hi_r <= (!aresetn || !ser_out.txd) ? 32'h0 : hi_r + 32'h1;
  end
  //////////
  tog_start_a: assert property (tog && $fell(ser_out.txd)
    |-> !ser_out.rts_n && lo_r >= on_r * MS_CYC) else $error("toggle start too early");
  tog_rel_a: assert property (tog && $rose(ser_out.rts_n)
    |-> hi_r >= off_r * MS_CYC) else $error("toggle release too early");
  none_rts_a: assert property (cfg_r[5:4] == FLOW_NONE && cfg_r == $past(cfg_r, 3)
    |-> !ser_out.rts_n) else $error("rts moved without flow control");
  if_on_a: assert property (cfg_r[8:7] inside {IF_4WIRE, IF_P2P}
    && cfg_r == $past(cfg_r, 3) |-> ser_out.de) else $error("driver off in full duplex");
  if_off_a: assert property (cfg_r[8:7] == IF_SINGLE && cfg_r == $past(cfg_r, 3)
    |-> !ser_out.de) else $error("driver on in single ended");
  rd_lat_a: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid) else $error("read answer late");
  ar_busy_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
  wr_resp_a: assert property (wr && axi_req.awaddr != ADDR_TXDATA
    && axi_req.awaddr != ADDR_RXDATA |-> ##2 axi_rsp.bvalid
    && axi_rsp.bresp == ($past(map, 2) ? RESP_OKAY : RESP_SLVERR)) else $error("bad write reply");
  cover property (tog && $fell(ser_out.txd));
  cover property (wr && !map);
  cover property (ser_out.de && cfg_r[8:7] == IF_4WIRE);
endmodule

bind spu_uart spu_uart_props #(.MS_CYC(MS_CYC)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .ser_in(ser_in), .ser_out(ser_out));

//--- sim/spu_far.sv
module spu_far (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int         baud = 4;
  logic [2:0] par  = 3'h0;
  logic       s2   = 1'b0;
  logic       bad  = 1'b0;
  logic [9:0] c;
  logic [9:0] rx_q [$];
  initial rxd = 1'b1;
  function automatic logic pb(input logic [7:0] d);
    case (par)
      3'h1: return ~^d;
      3'h2: return ^d;
      3'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (baud) @(posedge aclk);
  endtask
  // Frame matches the port settings; bad flips the parity bit
  task automatic send(input logic [7:0] d);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par != 3'h0) bit_out(pb(d) ^ bad);
    bit_out(1'b1);
    if (s2) bit_out(1'b1);
  endtask
  //////////
  // Mid-bit sampling; pushes {stop, parity, data}
  initial forever begin
    @(negedge txd);
    repeat (baud / 2) @(posedge aclk);
    if (!txd) begin
      c = '0;
      for (int i = 0; i < 8; i++) begin
        repeat (baud) @(posedge aclk);
        c[i] = txd;
      end
      if (par != 3'h0) begin
        repeat (baud) @(posedge aclk);
        c[8] = txd;
      end
      repeat (baud) @(posedge aclk);
      c[9] = txd;
      rx_q.push_back(c);
    end
  end
endmodule

//--- sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spu_pkg::*;
  logic         aclk    = 1'b0;
  logic         aresetn = 1'b0;
  logic         cts_n   = 1'b0;
  logic         rxd;
  spu_axi_req_t req     = '0;
  spu_axi_rsp_t rsp;
  spu_ser_out_t so;
  logic [31:0]  v;
  logic [1:0]   r;
  logic [9:0]   g;
  logic [7:0]   b [3];
  int           n_fail  = 0;
  int           n_tests = 0;
  spu_uart #(.MS_CYC(10)) dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .ser_in({rxd, cts_n}), .ser_out(so));
  spu_far far_u (.aclk(aclk), .txd(so.txd), .rxd(rxd));
  initial forever #50 aclk = ~aclk;
  //////////
  task automatic summarize;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic s);
    chk(nm, 32'(e), 32'(s));
  endtask
  task automatic tmo(input int k);
    if (k >= 5000) begin
      n_fail++;
      $display("BAD wait exp done got timeout");
      summarize();
    end
  endtask
  function automatic logic ep(input logic [2:0] m, input logic [7:0] d);
    return (m == 3'h1) ? ~^d : (m == 3'h2) ? ^d : (m == 3'h3);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (k = 0; k < 5000; k++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    tmo(k);
    req.bready <= 1'b0;
    r = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (k = 0; k < 5000; k++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    tmo(k);
    req.rready <= 1'b0;
    v = rsp.rdata;
    r = rsp.rresp;
  endtask
  task automatic setc(input int p, input int s, input int f, input int fi, input int i);
    wr(ADDR_CFG, 32'(i << 7 | fi << 6 | f << 4 | s << 3 | p));
    far_u.par = 3'(p);
    far_u.s2 = 1'(s);
  endtask
  task automatic getc(input logic [7:0] e, input logic [2:0] m);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge aclk);
      if (far_u.rx_q.size() > 0) break;
    end
    tmo(k);
    g = far_u.rx_q.pop_front();
    chk("tx_char", 32'({1'b1, ep(m, e), e}), 32'(g));
  endtask
  task automatic rxchk(input logic [7:0] e);
    int k;
    for (k = 0; k < 5000; k++) begin
      rd(ADDR_RXDATA);
      if (v[8] === 1'b1) break;
    end
    tmo(k);
    chk("rx_char", 32'({1'b1, e}), 32'(v[8:0]));
  endtask
  //////////
  initial begin
    v = $urandom(32'hABDD);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_BAUD);
    chk("baud_rst", 32'(BAUD_RST), v);
    rd(ADDR_CFG);
    chk("cfg_rst", 32'(CFG_RST), v);
    rd(8'h20);
    chk("rd_unmap", 32'(RESP_SLVERR), 32'(r));
    wr(8'h20, 32'h0);
    chk("wr_unmap", 32'(RESP_SLVERR), 32'(r));
    wr(ADDR_BAUD, 32'd200000);
    rd(ADDR_BAUD);
    chk("baud_slow", 32'd200000, v);
    wr(ADDR_BAUD, 32'h4);
    far_u.baud = 4;
    wr(ADDR_RTSDLY, 32'h0078_0065);
    rd(ADDR_RTSDLY);
    chk("dly_clamp", 32'h0064_0064, v);
    for (int m = 0; m < 10; m++) begin
      setc(m % 5, m / 5, FLOW_NONE, 1, IF_SINGLE);
      b[0] = (m == 0) ? 8'h00 : (m == 9) ? 8'hFF : 8'($urandom);
      wr(ADDR_TXDATA, {24'h0, b[0]});
      getc(b[0], 3'(m % 5));
      b[1] = 8'($urandom);
      far_u.send(b[1]);
      rxchk(b[1]);
    end
    far_u.bad = 1'b1;
    far_u.send(8'h5A);
    far_u.bad = 1'b0;
    rd(ADDR_RXDATA);
    rd(ADDR_STATUS);
    chkb("par_err", 1'b1, v[ST_PERR]);
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_STATUS, 32'h38);
      setc(0, 0, FLOW_NONE, f, IF_SINGLE);
      b[0] = 8'($urandom);
      b[1] = 8'($urandom);
      far_u.send(b[0]);
      far_u.send(b[1]);
      // Let the receiver finish the second character's stop bit before looking
      repeat (8) @(posedge aclk);
      rd(ADDR_STATUS);
      chkb("overrun", 1'(f == 0), v[ST_OVR]);
      rxchk(b[0]);
      if (f == 1) rxchk(b[1]);
    end
    // Clear-to-send goes inactive and settles before anything is queued
    cts_n <= 1'b1;
    setc(0, 0, FLOW_HW, 1, IF_4WIRE);
    for (int i = 0; i < 3; i++) b[i] = 8'($urandom);
    wr(ADDR_TXDATA, {24'h0, b[0]});
    wr(ADDR_TXDATA, {24'h0, b[1]});
    chkb("rts_room", 1'b0, so.rts_n);
    chkb("de_4w", 1'b1, so.de);
    fork
      wr(ADDR_TXDATA, {24'h0, b[2]});
      begin
        repeat (300) @(posedge aclk);
        chk("cts_hold", 32'h0, 32'(far_u.rx_q.size()));
        cts_n <= 1'b0;
      end
    join
    for (int i = 0; i < 3; i++) getc(b[i], 3'h0);
    repeat (50) @(posedge aclk);
    wr(ADDR_RTSDLY, 32'h0002_0001);
    setc(0, 0, FLOW_TOGGLE, 1, IF_2WIRE);
    repeat (50) @(posedge aclk);
    chkb("rts_idle", 1'b1, so.rts_n);
    chkb("de_idle", 1'b0, so.de);
    wr(ADDR_TXDATA, {24'h0, b[0]});
    wr(ADDR_TXDATA, {24'h0, b[1]});
    getc(b[0], 3'h0);
    chkb("re_tx", 1'b1, so.re_n);
    getc(b[1], 3'h0);
    repeat (60) @(posedge aclk);
    chkb("rts_done", 1'b1, so.rts_n);
    for (int i = 0; i < 4; i++) begin
      setc(0, 0, FLOW_NONE, 1, i);
      repeat (4) @(posedge aclk);
      chkb("de_if", 1'(i >= 2), so.de);
      chkb("re_if", 1'b0, so.re_n);
    end
    summarize();
  end
endmodule
